// ==== sim/rmpi_monitor.sv ====
// checker for the rmii pin block
`default_nettype none
module rmpi_monitor #(parameter MGMT_DIV = 4) (
    // pins watched
    input wire CLK_SYS, RST_N, LINK_REF_CLOCK, RX_SYMBOL_ERROR,
    input wire [1:0] TX_DIBIT_BUS, RX_DIBIT_BUS, RX_DIBIT,
    input wire TX_FRAME_ENABLE, RX_DIBIT_VALID, RX_CRC_ERROR,
    input wire MGMT_CLOCK_OUT, MGMT_DATA_O, MGMT_DATA_OE, MGMT_DONE, MGMT_BUSY
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic [7:0] run;
    // cycles since the management clock moved; ff means not yet timed
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            run <= 8'hFF;
        end else if (!MGMT_BUSY) begin
            run <= 8'hFF;
        end else begin
            run <= $changed(MGMT_CLOCK_OUT) ? 8'h00 : run + {7'h00, run != 8'hFF};
        end
    end
    // ****
    // properties
    // ****
    sequence s_tx_idle;
        !TX_FRAME_ENABLE && TX_DIBIT_BUS == 2'b00;
    endsequence
    AST_TXEN_FIRST: assert property ($rose(TX_FRAME_ENABLE) |-> TX_DIBIT_BUS == 2'b01)
        else $error("enable rose without preamble");
    AST_TXEN_TAIL: assert property ($fell(TX_FRAME_ENABLE) |-> s_tx_idle ##1 s_tx_idle)
        else $error("bus not idle after enable fell");
    AST_TX_REF_STEP: assert property ($changed({TX_FRAME_ENABLE, TX_DIBIT_BUS})
        |-> $past(LINK_REF_CLOCK, 2)) else $error("transmit changed off reference");
    AST_RX_DIBIT: assert property (RX_DIBIT_VALID |-> $past(LINK_REF_CLOCK, 2)
        && RX_DIBIT == $past(RX_DIBIT_BUS, 2)) else $error("receive di-bit wrong");
    AST_CRC_CAUSE: assert property ($rose(RX_CRC_ERROR) |-> $past(RX_SYMBOL_ERROR, 3))
        else $error("crc flag without error");
    AST_MDC_HALF: assert property ($changed(MGMT_CLOCK_OUT) && run != 8'hFF
        |-> run == MGMT_DIV - 1) else $error("management clock half period wrong");
    AST_MDIO_FALL: assert property (MGMT_DATA_OE && $changed(MGMT_DATA_O)
        |-> $fell(MGMT_CLOCK_OUT)) else $error("management data moved off falling edge");
    AST_MGMT_END: assert property (MGMT_DONE |-> !MGMT_DATA_OE ##1 !MGMT_DONE)
        else $error("management end wrong");
endmodule // rmpi_monitor
bind rmpi_pins rmpi_monitor #(.MGMT_DIV(MGMT_DIV)) i_rmpi_monitor (.CLK_SYS(CLK_SYS),
    .RST_N(RST_N), .LINK_REF_CLOCK(LINK_REF_CLOCK), .RX_SYMBOL_ERROR(RX_SYMBOL_ERROR),
    .TX_DIBIT_BUS(TX_DIBIT_BUS), .RX_DIBIT_BUS(RX_DIBIT_BUS), .RX_DIBIT(RX_DIBIT),
    .TX_FRAME_ENABLE(TX_FRAME_ENABLE), .RX_DIBIT_VALID(RX_DIBIT_VALID),
    .RX_CRC_ERROR(RX_CRC_ERROR), .MGMT_CLOCK_OUT(MGMT_CLOCK_OUT), .MGMT_DATA_O(MGMT_DATA_O),
    .MGMT_DATA_OE(MGMT_DATA_OE), .MGMT_DONE(MGMT_DONE), .MGMT_BUSY(MGMT_BUSY));
`default_nettype wire

// ==== sim/rmpi_phy_model.sv ====
// phy-side partner for the rmii pin block
`default_nettype none
module rmpi_phy_model (
    // link pins toward the mac
    output logic ref_clk, crs, rxer,
    output logic [1:0] rxd,
    // management pins
    input wire logic mdc, mdio, mac_oe,
    output logic phy_oe, phy_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic turn = 1'b1;
    logic [31:0] seen = 32'h0000_0000;
    // free-running reference clock
    initial begin
        {ref_clk, crs, rxer, rxd, phy_oe, phy_bit} = 7'h00;
        forever #24 ref_clk = ~ref_clk;
    end
    // one frame; data moves on the fall so it is settled at the rise
    task automatic frame(input int n, input int err_at);
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            crs <= 1'b1;
            rxd <= 2'(i) ^ 2'b10;
            rxer <= (i == err_at || i == err_at + 1);
        end
        @(negedge ref_clk);
        crs <= 1'b0;
        rxer <= 1'b0;
        rxd <= ~rxd; // stale data must not look valid
    endtask
    // capture on the rise, answer zeros on the fall once the mac lets go
    always @(posedge mdc) begin
        turn <= !mac_oe;
        if (mac_oe) seen <= {seen[30:0], mdio};
    end
    always @(negedge mdc) begin
        phy_oe <= turn;
        phy_bit <= 1'b0;
    end
endmodule // rmpi_phy_model
`default_nettype wire

// ==== sim/tb.sv ====
// testbench for the rmii pin block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, t_go = 0, t_last = 0, m_go = 0;
    logic [1:0] t_d = 2'b10;
    logic [31:0] m_frame = 32'h0000_0000, m_mask = 32'h0000_0000;
    wire rc, crs, rxer, t_en, take, t_busy, r_v, r_end, r_err, mco, mdo, mdoe, m_done, m_busy;
    wire phy_oe, phy_bit;
    wire [1:0] rxd, t_bus, r_d;
    wire [31:0] cap;
    wire [4:0] flags = {r_end, m_done, m_busy, t_busy, t_en};
    wire mdio = mdoe ? mdo : (phy_oe ? phy_bit : 1'b1); // pull-up when released
    int failures = 0, check_count = 0, rx_n = 0, t_i = 0;
    rmpi_pins #(.PREAMBLE_DIBITS(8'h03), .MGMT_DIV(8'h04)) i_rmpi_pins (.CLK_SYS(clk),
        .RST_N(rst_n), .LINK_REF_CLOCK(rc), .RX_DIBIT_BUS(rxd), .CARRIER_RX_VALID(crs),
        .RX_SYMBOL_ERROR(rxer), .TX_DIBIT_BUS(t_bus), .TX_FRAME_ENABLE(t_en),
        .MGMT_CLOCK_OUT(mco), .MGMT_DATA_O(mdo), .MGMT_DATA_OE(mdoe), .MGMT_DATA_I(mdio),
        .TX_START(t_go), .TX_DIBIT(t_d), .TX_LAST(t_last), .TX_TAKE(take), .TX_BUSY(t_busy),
        .RX_DIBIT(r_d), .RX_DIBIT_VALID(r_v), .RX_FRAME_END(r_end), .RX_CRC_ERROR(r_err),
        .MGMT_START(m_go), .MGMT_FRAME(m_frame), .MGMT_DRIVE_MASK(m_mask),
        .MGMT_CAPTURE(cap), .MGMT_DONE(m_done), .MGMT_BUSY(m_busy));
    rmpi_phy_model i_rmpi_phy_model (.ref_clk(rc), .crs(crs), .rxer(rxer), .rxd(rxd),
        .mdc(mco), .mdio(mdio), .mac_oe(mdoe), .phy_oe(phy_oe), .phy_bit(phy_bit));
    initial forever #2.5 clk = ~clk;
    task check(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task wait_flag(input int k, input logic v);
        for (int n = 0; n < 4000; n++) begin
            @(posedge clk);
            #1;
            if (flags[k] === v) return;
        end
        failures++;
        tally_and_finish;
    endtask
    // received di-bits must arrive in the partner's order
    always @(posedge clk) begin
        if (r_v === 1'b1) begin
            check("rx dibit", r_d, rx_n[1:0] ^ 2'b10);
            rx_n <= rx_n + 1;
        end
        if (take === 1'b1) begin
            t_i <= t_i + 1;
            t_d <= t_d + 2'b01;
            t_last <= (t_i == 3);
        end
    end
    // automatic so the queues start empty on every call
    task automatic tx_frame;
        logic [1:0] seen[$];
        logic [1:0] exp[$];
        exp = {2'b01, 2'b01, 2'b01, 2'b11, 2'b10, 2'b11, 2'b00, 2'b01, 2'b10};
        @(posedge clk);
        t_i <= 0;
        t_d <= 2'b10;
        t_last <= 1'b0;
        t_go <= 1'b1;
        wait_flag(1, 1'b1);
        @(posedge clk) t_go <= 1'b0;
        for (int n = 0; n < 40 && seen.size() < 12; n++) begin
            @(posedge rc);
            if (t_en === 1'b1) seen.push_back(t_bus);
            else if (seen.size() > 0) break;
        end
        check("tx count", seen.size(), exp.size());
        foreach (exp[i]) check("tx dibit", seen[i], exp[i]);
        wait_flag(1, 1'b0);
        $display("tx frame done");
    endtask
    task rx_frames;
        i_rmpi_phy_model.frame(8, 2);
        wait_flag(4, 1'b1);
        check("rx count", rx_n, 8);
        check("rx crc", r_err, 1'b1);
        i_rmpi_phy_model.frame(4, 99);
        wait_flag(4, 1'b1);
        check("rx count", rx_n, 12);
        check("rx crc", r_err, 1'b0);
        $display("rx frames done");
    endtask
    task mgmt_op(input logic [31:0] mask, frame, exp);
        @(posedge clk);
        m_mask <= mask;
        m_frame <= frame;
        m_go <= 1'b1;
        wait_flag(2, 1'b1);
        @(posedge clk) m_go <= 1'b0;
        wait_flag(3, 1'b1);
        check("mgmt capture", cap, exp);
        if (mask[31]) check("phy capture", i_rmpi_phy_model.seen, frame);
        $display("management op done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        tx_frame;
        tx_frame;
        rx_frames;
        mgmt_op(32'h0000_0000, 32'hA5C3_0F96, 32'h0000_0000);
        mgmt_op(32'hFFFF_FFFF, 32'hA5C3_0F96, 32'hA5C3_0F96);
        tally_and_finish;
    end
endmodule // tb
`default_nettype wire

// ==== verilog/rmpi_map.vh ====
// constants for the reduced media-independent pin interface block
`ifndef RMPI_MAP_VH
`define RMPI_MAP_VH
`define RMPI_DIBIT_W 2
`define RMPI_PREAMBLE_DIBIT 2'b01
`define RMPI_SFD_LAST_DIBIT 2'b11
`define RMPI_MGMT_DIV 8'h0A
`define RMPI_MGMT_BITS 6'h20
`define RMPI_ST_IDLE 2'b00
`define RMPI_ST_PREAMBLE 2'b01
`define RMPI_ST_DATA 2'b10
`define RMPI_ST_LAST 2'b11
`endif

// ==== verilog/rmpi_pins.v ====
// reduced media-independent pin interface and management serial link, mac side
`include "rmpi_map.vh"
`default_nettype none
module rmpi_pins #(
    parameter PREAMBLE_DIBITS = 8'h1F,
    parameter MGMT_DIV = `RMPI_MGMT_DIV
) (
    // clock and reset
    input wire CLK_SYS,
    input wire RST_N,
    // link pins from the phy side
    input wire LINK_REF_CLOCK,
    input wire [1:0] RX_DIBIT_BUS,
    input wire CARRIER_RX_VALID,
    input wire RX_SYMBOL_ERROR,
    // transmit pins
    output reg [1:0] TX_DIBIT_BUS,
    output reg TX_FRAME_ENABLE,
    // management pins
    output reg MGMT_CLOCK_OUT,
    output reg MGMT_DATA_O,
    output reg MGMT_DATA_OE,
    input wire MGMT_DATA_I,
    // user transmit side
    input wire TX_START,
    input wire [1:0] TX_DIBIT,
    input wire TX_LAST,
    output reg TX_TAKE,
    output reg TX_BUSY,
    // user receive side
    output reg [1:0] RX_DIBIT,
    output reg RX_DIBIT_VALID,
    output reg RX_FRAME_END,
    output reg RX_CRC_ERROR,
    // user management side
    input wire MGMT_START,
    input wire [31:0] MGMT_FRAME,
    input wire [31:0] MGMT_DRIVE_MASK,
    output reg [31:0] MGMT_CAPTURE,
    output reg MGMT_DONE,
    output reg MGMT_BUSY
);
    // ***************************************************
    // input synchronisation
    // ***************************************************
    wire [5:1] pin_sync;
    wire mdio_sync;
    rmpi_sync2 #(.W(6)) u_sync (
        .CLK_SYS(CLK_SYS),
        .RST_N(RST_N),
        .async_in({LINK_REF_CLOCK, RX_DIBIT_BUS, CARRIER_RX_VALID, RX_SYMBOL_ERROR,
            MGMT_DATA_I}),
        .sync_out({pin_sync[5:1], mdio_sync})
    );
    wire ref_s = pin_sync[5];
    wire [1:0] rxd_s = pin_sync[4:3];
    wire crs_s = pin_sync[2];
    wire err_s = pin_sync[1];

    reg ref_d;
    // rising edge of the reference clock found by the system clock
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ref_d <= 1'b0;
        end else begin
            ref_d <= ref_s;
        end
    end
    wire ref_rise = ref_s & ~ref_d;

    // ***************************************************
    // transmit
    // ***************************************************
    reg [1:0] tx_state;
    reg [7:0] pre_cnt;
    // frame sequencer: preamble, data, then drop enable
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            tx_state <= `RMPI_ST_IDLE;
            pre_cnt <= 8'h00;
            TX_DIBIT_BUS <= 2'b00;
            TX_FRAME_ENABLE <= 1'b0;
            TX_TAKE <= 1'b0;
            TX_BUSY <= 1'b0;
        end else begin
            TX_TAKE <= 1'b0;
            if (ref_rise) begin
                case (tx_state)
                    `RMPI_ST_IDLE: begin
                        if (TX_START) begin
                            tx_state <= `RMPI_ST_PREAMBLE;
                            pre_cnt <= 8'h00;
                            TX_DIBIT_BUS <= `RMPI_PREAMBLE_DIBIT;
                            TX_FRAME_ENABLE <= 1'b1;
                            TX_BUSY <= 1'b1;
                        end
                    end
                    `RMPI_ST_PREAMBLE: begin
                        pre_cnt <= pre_cnt + 8'h01;
                        if (pre_cnt == PREAMBLE_DIBITS[7:0] - 8'h01) begin
                            TX_DIBIT_BUS <= `RMPI_SFD_LAST_DIBIT;
                            tx_state <= `RMPI_ST_DATA;
                        end else begin
                            TX_DIBIT_BUS <= `RMPI_PREAMBLE_DIBIT;
                        end
                    end
                    `RMPI_ST_DATA: begin
                        TX_DIBIT_BUS <= TX_DIBIT;
                        TX_TAKE <= 1'b1;
                        TX_FRAME_ENABLE <= 1'b1;
                        if (TX_LAST) begin
                            tx_state <= `RMPI_ST_LAST;
                        end
                    end
                    `RMPI_ST_LAST: begin
                        // enable falls only after the last di-bit's full cycle
                        TX_FRAME_ENABLE <= 1'b0;
                        TX_DIBIT_BUS <= 2'b00;
                        TX_BUSY <= 1'b0;
                        tx_state <= `RMPI_ST_IDLE;
                    end
                    default: begin
                        tx_state <= `RMPI_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ***************************************************
    // receive
    // ***************************************************
    reg in_frame;
    // di-bits sampled at reference rise; error inside a frame marks crc error
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            in_frame <= 1'b0;
            RX_DIBIT <= 2'b00;
            RX_DIBIT_VALID <= 1'b0;
            RX_FRAME_END <= 1'b0;
            RX_CRC_ERROR <= 1'b0;
        end else begin
            RX_DIBIT_VALID <= 1'b0;
            RX_FRAME_END <= 1'b0;
            if (ref_rise) begin
                // carrier-valid falls on a di-bit boundary, so it ends the frame cleanly
                in_frame <= crs_s;
                if (crs_s) begin
                    RX_DIBIT <= rxd_s;
                    RX_DIBIT_VALID <= 1'b1;
                    if (!in_frame) begin
                        RX_CRC_ERROR <= err_s;
                    end else if (err_s) begin
                        RX_CRC_ERROR <= 1'b1;
                    end
                end else if (in_frame) begin
                    RX_FRAME_END <= 1'b1;
                end
            end
        end
    end

    // ***************************************************
    // management serial link
    // ***************************************************
    reg [7:0] div_cnt;
    reg [5:0] bit_cnt;
    reg [31:0] shift_out;
    reg [31:0] mask;
    // mac sources the management clock by dividing the system clock
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            div_cnt <= 8'h00;
            bit_cnt <= 6'h00;
            shift_out <= 32'h0000_0000;
            mask <= 32'h0000_0000;
            MGMT_CLOCK_OUT <= 1'b0;
            MGMT_DATA_O <= 1'b0;
            MGMT_DATA_OE <= 1'b0;
            MGMT_CAPTURE <= 32'h0000_0000;
            MGMT_DONE <= 1'b0;
            MGMT_BUSY <= 1'b0;
        end else begin
            MGMT_DONE <= 1'b0;
            if (!MGMT_BUSY) begin
                // clock steps high on start so its first toggle is a fall that sets up
                // bit 31 a half period ahead of the first capture; no unpaired rise
                MGMT_CLOCK_OUT <= MGMT_START;
                MGMT_DATA_OE <= 1'b0;
                if (MGMT_START) begin
                    MGMT_BUSY <= 1'b1;
                    shift_out <= MGMT_FRAME;
                    mask <= MGMT_DRIVE_MASK;
                    bit_cnt <= 6'h00;
                    div_cnt <= 8'h00;
                end
            end else if (div_cnt == MGMT_DIV[7:0] - 8'h01) begin
                div_cnt <= 8'h00;
                MGMT_CLOCK_OUT <= ~MGMT_CLOCK_OUT;
                if (!MGMT_CLOCK_OUT) begin
                    // rising edge: the mac latches the line here; the phy latches it only on bits the mac drives
                    MGMT_CAPTURE <= {MGMT_CAPTURE[30:0], mdio_sync};
                    bit_cnt <= bit_cnt + 6'h01;
                end else if (bit_cnt == `RMPI_MGMT_BITS) begin
                    MGMT_BUSY <= 1'b0;
                    MGMT_DONE <= 1'b1;
                    MGMT_DATA_OE <= 1'b0;
                end else begin
                    // falling edge: change data half a period before the capture
                    MGMT_DATA_O <= shift_out[31];
                    MGMT_DATA_OE <= mask[31];
                    shift_out <= {shift_out[30:0], 1'b0};
                    mask <= {mask[30:0], 1'b0};
                end
            end else begin
                div_cnt <= div_cnt + 8'h01;
            end
        end
    end
endmodule // rmpi_pins
`default_nettype wire

// ==== verilog/rmpi_sync2.v ====
// two-flop synchroniser for inputs from outside the system clock domain
`default_nettype none
module rmpi_sync2 #(
    parameter W = 1
) (
    // clock and reset
    input wire CLK_SYS,
    input wire RST_N,
    // signal
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta;

    // first stage feeds only the second stage
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            meta <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // rmpi_sync2
`default_nettype wire
